// >>> hdl/icpdr_pkg.sv
// Constants and types shared by the input clock and PLL divider register slice
package icpdr_pkg;
	// Bus geometry
	localparam int ICPDR_ADDR_W = 8;
	localparam int ICPDR_DATA_W = 32;
	// Register indices; byte address is four times the index
	localparam logic [5:0] ICPDR_IDX_INPUT_CLOCK_CONTROL = 6'h33;
	localparam logic [5:0] ICPDR_IDX_REFERENCE_DIVIDER = 6'h34;
	localparam logic [5:0] ICPDR_IDX_MULTIPLIER_DIVIDER = 6'h35;
	localparam logic [5:0] ICPDR_IDX_REF_PATH_STATUS = 6'h36;
	// Values after reset
	localparam logic [7:0] ICPDR_RST_INPUT_CLOCK_CONTROL = 8'h03;
	localparam logic [2:0] ICPDR_RST_REFERENCE_DIVIDER = 3'h0;
	localparam logic [4:0] ICPDR_RST_MULTIPLIER_DIVIDER = 5'h00;
	// Field positions in input_clock_control
	localparam int ICPDR_BIT_INPUT_MUX_BYPASS = 7;
	localparam int ICPDR_BIT_KEEP_ALT_OSC = 2;
	localparam int ICPDR_BIT_ALT_BUFFER_GAIN = 1;
	localparam int ICPDR_BIT_MAIN_BUFFER_GAIN = 0;
	// Field positions in ref_path_status
	localparam int ICPDR_BIT_STAT_ACTIVE_ALT = 0;
	localparam int ICPDR_BIT_STAT_ALT_BUF_ON = 1;
	// Divider field widths
	localparam int ICPDR_REF_DIV_W = 3;
	localparam int ICPDR_M_DIV_W = 5;
	// Bus slave states
	typedef enum logic [0:0]
	{
		ICPDR_BUS_IDLE = 1'b0,
		ICPDR_BUS_ACK = 1'b1
	} icpdr_bus_state_t;
endpackage

// >>> hdl/icpdr_ref_mux.sv
// Glitch-less reference multiplexer with a bypass path
`timescale 1ns/1ps
`default_nettype none
module icpdr_ref_mux
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_main_ref,
	input wire logic i_alt_ref,
	input wire logic i_sel_alt,
	input wire logic i_bypass,
	output logic o_ref,
	output logic o_active_alt
);
	logic out_ff;
	logic active_ff;
	logic cur_src;
	logic new_src;

	// Source now feeding the output and the one requested
	assign cur_src = active_ff ? i_alt_ref : i_main_ref;
	assign new_src = i_sel_alt ? i_alt_ref : i_main_ref;

	// Selection follows at once in bypass, else only while the output and the requested source are low
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			active_ff <= 1'b0;
		else if (i_bypass)
			active_ff <= i_sel_alt;
		else if ((active_ff != i_sel_alt) && !out_ff && !new_src)
			active_ff <= i_sel_alt;
	end

	// Output level; the switch cycle is forced low so no runt pulse escapes
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			out_ff <= 1'b0;
		else if (i_bypass)
			out_ff <= new_src;
		else if ((active_ff != i_sel_alt) && !out_ff && !new_src)
			out_ff <= 1'b0;
		else
			out_ff <= cur_src;
	end

	assign o_ref = out_ff;
	assign o_active_alt = active_ff;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	property p_bypass_direct;
		i_bypass |=> (out_ff == $past(new_src));
	endproperty
	a_bypass_direct: assert property (p_bypass_direct)
		else $error("bypassed mux output does not follow selected source");

	property p_glitchless_rise;
		(!$past(i_bypass) && $rose(out_ff)) |-> $past(cur_src);
	endproperty
	a_glitchless_rise: assert property (p_glitchless_rise)
		else $error("glitch-less mux output rose without its active source");
endmodule
`default_nettype wire

// >>> hdl/icpdr_ratio_div.sv
// Programmable ratio divider: code zero bypasses, code n divides by n plus one
`timescale 1ns/1ps
`default_nettype none
module icpdr_ratio_div
#(
	parameter int W = 3
)
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_in,
	input wire logic [W-1:0] i_ratio,
	output logic o_out
);
	logic in_d_ff;
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic out_ff;
	logic rise;
	logic wrap;
	logic [W-1:0] ratio_d_ff;
	logic settled_ff;

	// High time in input periods, rounded up for odd ratios
	function automatic logic [W:0] half_of(input logic [W-1:0] code);
		logic [W:0] sum;
		sum = {1'b0, code} + {{(W-1){1'b0}}, 2'b10};
		return sum >> 1;
	endfunction

	assign rise = i_in && !in_d_ff;
	assign wrap = rise && (cnt_ff >= i_ratio);
	assign nxt_cnt = (cnt_ff >= i_ratio) ? '0 : (cnt_ff + {{(W-1){1'b0}}, 1'b1});

	// Edge detect on the input level
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			in_d_ff <= 1'b0;
		else
			in_d_ff <= i_in;
	end

	// Counts input rises; a shrunk ratio wraps on the next rise
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			cnt_ff <= '0;
		else if (i_ratio == '0)
			cnt_ff <= '0;
		else if (rise)
			cnt_ff <= nxt_cnt;
	end

	// Bypass passes the level, else high for the first half of each cycle
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			out_ff <= 1'b0;
		else if (i_ratio == '0)
			out_ff <= i_in;
		else if (rise)
			out_ff <= ({1'b0, nxt_cnt} < half_of(i_ratio));
	end

	assign o_out = out_ff;

	// Check helper: last cycle's code, so a ratio change can be seen
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			ratio_d_ff <= '0;
		else
			ratio_d_ff <= i_ratio;
	end

	// Check helper: a wrap seen since the code last changed; before it the phase is irregular
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			settled_ff <= 1'b0;
		else if (i_ratio != ratio_d_ff)
			settled_ff <= 1'b0;
		else if (wrap)
			settled_ff <= 1'b1;
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	property p_div_bypass;
		(i_ratio == '0) |=> (out_ff == $past(i_in));
	endproperty
	a_div_bypass: assert property (p_div_bypass)
		else $error("divider at code zero does not pass its input");

	property p_div_wrap;
		($rose(out_ff) && $past(settled_ff) && $past(i_ratio == ratio_d_ff) && ($past(i_ratio) != '0))
			|-> $past(wrap);
	endproperty
	a_div_wrap: assert property (p_div_wrap)
		else $error("divided output rose away from a count wrap");
endmodule
`default_nettype wire

// >>> hdl/icpdr_regs_top.sv
// Input clock control and PLL divider registers with Avalon-MM slave
//
// Behaviour
// - Bypass bit routes references around the glitch-less mux; resets to zero.
// - Keep bit zero: alternate buffer turns off after returning to main input.
// - Keep bit one: alternate buffer stays powered after returning to main input.
// - Alternate buffer gain bit: zero minimum, one maximum; resets to one.
// - Main buffer gain bit: zero minimum, one maximum; resets to one.
// - Reference divider code zero bypasses; code n divides by n plus one.
// - M divider code zero bypasses; code n divides by n plus one.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module icpdr_regs_top
(
	input wire logic I_SYS_CLK,
	input wire logic I_ARST_N,
	input wire logic [7:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	input wire logic I_MAIN_REF,
	input wire logic I_ALT_REF,
	input wire logic I_REF_SEL_ALT,
	output logic O_PLL_REF,
	output logic O_ALT_BUF_EN,
	output logic O_ALT_BUF_GAIN_MAX,
	output logic O_MAIN_BUF_GAIN_MAX
);
	icpdr_pkg::icpdr_bus_state_t state_ff;
	logic waitreq_ff;
	logic [31:0] readdata_ff;
	logic [31:0] nxt_readdata;
	logic [7:0] input_clock_control_ff;
	logic [2:0] reference_divider_ff;
	logic [4:0] multiplier_divider_ff;
	logic alt_buf_en_ff;
	logic main_meta_ff;
	logic main_sync_ff;
	logic alt_meta_ff;
	logic alt_sync_ff;
	logic sel_meta_ff;
	logic sel_sync_ff;
	logic hit_ctl;
	logic hit_rdiv;
	logic hit_mdiv;
	logic hit_stat;
	logic req_take;
	logic wr_commit;
	logic wr_low_byte;
	logic active_alt;
	logic mux_ref;
	logic ref_div_out;
	logic input_mux_bypass;
	logic keep_alt_osc_after_return;

	// Word index match; the two low address bits are ignored
	function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
		return addr[7:2] == idx;
	endfunction

	assign hit_ctl = reg_hit(I_AVS_ADDRESS, icpdr_pkg::ICPDR_IDX_INPUT_CLOCK_CONTROL);
	assign hit_rdiv = reg_hit(I_AVS_ADDRESS, icpdr_pkg::ICPDR_IDX_REFERENCE_DIVIDER);
	assign hit_mdiv = reg_hit(I_AVS_ADDRESS, icpdr_pkg::ICPDR_IDX_MULTIPLIER_DIVIDER);
	assign hit_stat = reg_hit(I_AVS_ADDRESS, icpdr_pkg::ICPDR_IDX_REF_PATH_STATUS);

	// Request accepted in idle; write lands on the edge the master sees the answer
	assign req_take = (state_ff == icpdr_pkg::ICPDR_BUS_IDLE) && (I_AVS_READ || I_AVS_WRITE);
	assign wr_commit = (state_ff == icpdr_pkg::ICPDR_BUS_ACK) && I_AVS_WRITE;
	assign wr_low_byte = wr_commit && I_AVS_BYTEENABLE[0];

	// Field views
	assign input_mux_bypass = input_clock_control_ff[icpdr_pkg::ICPDR_BIT_INPUT_MUX_BYPASS];
	assign keep_alt_osc_after_return = input_clock_control_ff[icpdr_pkg::ICPDR_BIT_KEEP_ALT_OSC];

	// Pin synchronisers, two stages each
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			main_meta_ff <= 1'b0;
			main_sync_ff <= 1'b0;
		end
		else
		begin
			main_meta_ff <= I_MAIN_REF;
			main_sync_ff <= main_meta_ff;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			alt_meta_ff <= 1'b0;
			alt_sync_ff <= 1'b0;
		end
		else
		begin
			alt_meta_ff <= I_ALT_REF;
			alt_sync_ff <= alt_meta_ff;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			sel_meta_ff <= 1'b0;
			sel_sync_ff <= 1'b0;
		end
		else
		begin
			sel_meta_ff <= I_REF_SEL_ALT;
			sel_sync_ff <= sel_meta_ff;
		end
	end

	// Two-edge handshake: one wait cycle, then one answer cycle
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			state_ff <= icpdr_pkg::ICPDR_BUS_IDLE;
			waitreq_ff <= 1'b1;
		end
		else
		begin
			case (state_ff)
				icpdr_pkg::ICPDR_BUS_IDLE:
				begin
					if (req_take)
					begin
						state_ff <= icpdr_pkg::ICPDR_BUS_ACK;
						waitreq_ff <= 1'b0;
					end
				end
				icpdr_pkg::ICPDR_BUS_ACK:
				begin
					state_ff <= icpdr_pkg::ICPDR_BUS_IDLE;
					waitreq_ff <= 1'b1;
				end
				default:
				begin
					state_ff <= icpdr_pkg::ICPDR_BUS_IDLE;
					waitreq_ff <= 1'b1;
				end
			endcase
		end
	end

	// Read value; unmapped words and reserved divider bits read as zero
	always_comb
	begin
		nxt_readdata = 32'h00000000;
		if (hit_ctl)
			nxt_readdata[7:0] = input_clock_control_ff;
		else if (hit_rdiv)
			nxt_readdata[2:0] = reference_divider_ff;
		else if (hit_mdiv)
			nxt_readdata[4:0] = multiplier_divider_ff;
		else if (hit_stat)
		begin
			nxt_readdata[icpdr_pkg::ICPDR_BIT_STAT_ACTIVE_ALT] = active_alt;
			nxt_readdata[icpdr_pkg::ICPDR_BIT_STAT_ALT_BUF_ON] = alt_buf_en_ff;
		end
	end

	// Read data captured on accept and held through the answer cycle
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			readdata_ff <= 32'h00000000;
		else if (req_take && I_AVS_READ)
			readdata_ff <= nxt_readdata;
	end

	// Control byte; reserved bits are stored as written and read back
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			input_clock_control_ff <= icpdr_pkg::ICPDR_RST_INPUT_CLOCK_CONTROL;
		else if (wr_low_byte && hit_ctl)
			input_clock_control_ff <= I_AVS_WRITEDATA[7:0];
	end

	// Divider codes; bits above each field are dropped on write
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			reference_divider_ff <= icpdr_pkg::ICPDR_RST_REFERENCE_DIVIDER;
		else if (wr_low_byte && hit_rdiv)
			reference_divider_ff <= I_AVS_WRITEDATA[2:0];
	end

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			multiplier_divider_ff <= icpdr_pkg::ICPDR_RST_MULTIPLIER_DIVIDER;
		else if (wr_low_byte && hit_mdiv)
			multiplier_divider_ff <= I_AVS_WRITEDATA[4:0];
	end

	// Alternate buffer: on while selected, kept after return only if asked
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			alt_buf_en_ff <= 1'b0;
		else
			alt_buf_en_ff <= active_alt || (alt_buf_en_ff && keep_alt_osc_after_return);
	end

	// Reference path: mux, then reference divider, then M divider
	icpdr_ref_mux u_ref_mux
	(
		.i_clk(I_SYS_CLK),
		.i_arst_n(I_ARST_N),
		.i_main_ref(main_sync_ff),
		.i_alt_ref(alt_sync_ff),
		.i_sel_alt(sel_sync_ff),
		.i_bypass(input_mux_bypass),
		.o_ref(mux_ref),
		.o_active_alt(active_alt)
	);

	icpdr_ratio_div #(.W(icpdr_pkg::ICPDR_REF_DIV_W)) u_ref_div
	(
		.i_clk(I_SYS_CLK),
		.i_arst_n(I_ARST_N),
		.i_in(mux_ref),
		.i_ratio(reference_divider_ff),
		.o_out(ref_div_out)
	);

	icpdr_ratio_div #(.W(icpdr_pkg::ICPDR_M_DIV_W)) u_m_div
	(
		.i_clk(I_SYS_CLK),
		.i_arst_n(I_ARST_N),
		.i_in(ref_div_out),
		.i_ratio(multiplier_divider_ff),
		.o_out(O_PLL_REF)
	);

	// Outputs, each straight from a flip-flop
	assign O_AVS_READDATA = readdata_ff;
	assign O_AVS_WAITREQUEST = waitreq_ff;
	assign O_ALT_BUF_EN = alt_buf_en_ff;
	assign O_ALT_BUF_GAIN_MAX = input_clock_control_ff[icpdr_pkg::ICPDR_BIT_ALT_BUFFER_GAIN];
	assign O_MAIN_BUF_GAIN_MAX = input_clock_control_ff[icpdr_pkg::ICPDR_BIT_MAIN_BUFFER_GAIN];

	// Helper bits for the checks below
	logic wr_alt_gain;
	logic wr_main_gain;
	assign wr_alt_gain = I_AVS_WRITEDATA[icpdr_pkg::ICPDR_BIT_ALT_BUFFER_GAIN];
	assign wr_main_gain = I_AVS_WRITEDATA[icpdr_pkg::ICPDR_BIT_MAIN_BUFFER_GAIN];

	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	sequence s_ctl_commit;
		wr_low_byte && hit_ctl;
	endsequence

	sequence s_read_rdiv;
		req_take && I_AVS_READ && hit_rdiv;
	endsequence

	sequence s_read_mdiv;
		req_take && I_AVS_READ && hit_mdiv;
	endsequence

	sequence s_alt_return;
		$fell(active_alt);
	endsequence

	property p_answer_shape;
		req_take |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
	endproperty
	a_answer_shape: assert property (p_answer_shape)
		else $error("bus answer is not one wait then one ready cycle");

	property p_alt_off_after_return;
		(s_alt_return and !keep_alt_osc_after_return) |=> !O_ALT_BUF_EN;
	endproperty
	a_alt_off_after_return: assert property (p_alt_off_after_return)
		else $error("alternate buffer left on after return without keep");

	property p_alt_kept_after_return;
		(s_alt_return and (keep_alt_osc_after_return && O_ALT_BUF_EN)) |=> O_ALT_BUF_EN;
	endproperty
	a_alt_kept_after_return: assert property (p_alt_kept_after_return)
		else $error("alternate buffer dropped after return despite keep");

	property p_alt_gain_write;
		s_ctl_commit |=> (O_ALT_BUF_GAIN_MAX == $past(wr_alt_gain));
	endproperty
	a_alt_gain_write: assert property (p_alt_gain_write)
		else $error("alternate gain output does not follow written bit");

	property p_main_gain_write;
		s_ctl_commit |=> (O_MAIN_BUF_GAIN_MAX == $past(wr_main_gain));
	endproperty
	a_main_gain_write: assert property (p_main_gain_write)
		else $error("main gain output does not follow written bit");

	property p_rdiv_readback;
		s_read_rdiv |=> (O_AVS_READDATA == {29'h0000000, $past(reference_divider_ff)});
	endproperty
	a_rdiv_readback: assert property (p_rdiv_readback)
		else $error("reference divider readback wrong or reserved bits set");

	property p_mdiv_readback;
		s_read_mdiv |=> (O_AVS_READDATA == {27'h000000, $past(multiplier_divider_ff)});
	endproperty
	a_mdiv_readback: assert property (p_mdiv_readback)
		else $error("M divider readback wrong or reserved bits set");
endmodule
`default_nettype wire

// >>> verification/icpdr_regs_top_test.sv
// Self-checking testbench for the input clock and PLL divider register slice
`timescale 1ns/1ps
`default_nettype none
module icpdr_regs_top_test;
	localparam int LIMIT = 60000;
	localparam logic [5:0] CTL = icpdr_pkg::ICPDR_IDX_INPUT_CLOCK_CONTROL;
	localparam logic [5:0] RDV = icpdr_pkg::ICPDR_IDX_REFERENCE_DIVIDER;
	localparam logic [5:0] MDV = icpdr_pkg::ICPDR_IDX_MULTIPLIER_DIVIDER;
	localparam logic [5:0] STA = icpdr_pkg::ICPDR_IDX_REF_PATH_STATUS;
	logic sys_clk;
	logic arst_n;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic main_ref;
	logic alt_ref;
	logic ref_sel_alt;
	logic pll_ref;
	logic alt_buf_en;
	logic alt_gain_max;
	logic main_gain_max;
	int bad_count;
	int tests_run;
	int cycles;
	int ph;
	int m_ctl;
	int seed_ret;
	int per;
	int r_tab[4] = '{0, 1, 7, 3};
	int m_tab[4] = '{0, 1, 31, 9};

	icpdr_regs_top u_dut
	(
		.I_SYS_CLK(sys_clk),
		.I_ARST_N(arst_n),
		.I_AVS_ADDRESS(avs_address),
		.I_AVS_READ(avs_read),
		.I_AVS_WRITE(avs_write),
		.I_AVS_WRITEDATA(avs_writedata),
		.I_AVS_BYTEENABLE(avs_byteenable),
		.O_AVS_READDATA(avs_readdata),
		.O_AVS_WAITREQUEST(avs_waitrequest),
		.I_MAIN_REF(main_ref),
		.I_ALT_REF(alt_ref),
		.I_REF_SEL_ALT(ref_sel_alt),
		.O_PLL_REF(pll_ref),
		.O_ALT_BUF_EN(alt_buf_en),
		.O_ALT_BUF_GAIN_MAX(alt_gain_max),
		.O_MAIN_BUF_GAIN_MAX(main_gain_max)
	);

	// Clock, 4 ns period
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Free-running references: main period 4 cycles, alternate 6, so the mux choice shows in the period
	always @(posedge sys_clk)
	begin
		ph <= ph + 1;
		main_ref <= ((ph + 1) % 4) >= 2;
		alt_ref <= ((ph + 1) % 6) >= 3;
	end

	// Hang guard
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			bad_count++;
			$display("FAIL at %0t: cycles %h limit %h", $time, cycles, LIMIT);
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd, input logic [3:0] be,
		output logic [31:0] rd);
		@(posedge sys_clk);
		avs_address <= {idx, 2'b00};
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= wd;
		avs_byteenable <= be;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, idx, {24'h000000, d}, 4'hF, x);
	endtask

	task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, idx, 32'h00000000, 4'hF, x);
		chk(x, exp);
	endtask

	// Cycles between the third and fourth rise of the PLL reference, so ratio changes have settled
	task automatic meas(output int p);
		int n;
		int k;
		int s;
		logic pv;
		n = 0;
		k = 0;
		s = 0;
		pv = pll_ref;
		while (k < 4)
		begin
			@(posedge sys_clk);
			n++;
			if (pll_ref === 1'b1 && pv === 1'b0)
			begin
				k++;
				if (k == 3)
					s = n;
			end
			pv = pll_ref;
		end
		p = n - s;
	endtask

	// Wait until the status register reports the wanted active source
	task automatic wait_active(input logic want_alt);
		logic [31:0] x;
		do bus(1'b0, STA, 32'h00000000, 4'hF, x); while (x[0] !== want_alt);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		logic [31:0] x;
		int r;
		int m;
		arst_n = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
		ref_sel_alt = 1'b0;
		main_ref = 1'b0;
		alt_ref = 1'b0;
		ph = 0;
		cycles = 0;
		bad_count = 0;
		tests_run = 0;
		m_ctl = 8'h03;
		seed_ret = $urandom(71);
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		// Reset values and an unmapped word
		rd_chk(CTL, m_ctl);
		rd_chk(RDV, 32'h00000000);
		rd_chk(MDV, 32'h00000000);
		rd_chk(6'h00, 32'h00000000);
		chk(32'({alt_gain_max, main_gain_max}), 32'h00000003);
		chk(32'(alt_buf_en), 32'h00000000);
		$display("test reset values done");
		// Every gain combination, then a write with byte lane 0 off that must not land
		for (int i = 0; i < 4; i++)
		begin
			m_ctl = i;
			wr(CTL, m_ctl[7:0]);
			@(posedge sys_clk);
			chk(32'({alt_gain_max, main_gain_max}), i);
			rd_chk(CTL, m_ctl);
		end
		bus(1'b1, CTL, 32'h00000083, 4'hE, x);
		rd_chk(CTL, m_ctl);
		$display("test gain bits done");
		// Divider ratios on the main reference, mux bypassed; boundary codes plus random ones
		m_ctl = 8'h80;
		wr(CTL, m_ctl[7:0]);
		for (int i = 0; i < 6; i++)
		begin
			r = (i < 4) ? r_tab[i] : $urandom % 8;
			m = (i < 4) ? m_tab[i] : $urandom % 32;
			wr(RDV, r[7:0]);
			wr(MDV, m[7:0]);
			rd_chk(RDV, r);
			rd_chk(MDV, m);
			meas(per);
			chk(per, 4 * (r + 1) * (m + 1));
		end
		wr(RDV, 8'h00);
		wr(MDV, 8'h00);
		$display("test divider ratios done");
		// Source choice with the mux bypassed and with the glitch-less mux in the path
		for (int b = 1; b >= 0; b--)
		begin
			m_ctl = b << 7;
			wr(CTL, m_ctl[7:0]);
			rd_chk(CTL, m_ctl);
			ref_sel_alt <= 1'b1;
			wait_active(1'b1);
			meas(per);
			chk(per, 6);
			ref_sel_alt <= 1'b0;
			wait_active(1'b0);
			meas(per);
			chk(per, 4);
		end
		$display("test mux path done");
		// Alternate buffer after a return to the main input, keep bit off then on
		for (int k = 0; k < 2; k++)
		begin
			m_ctl = k << 2;
			wr(CTL, m_ctl[7:0]);
			ref_sel_alt <= 1'b1;
			wait_active(1'b1);
			chk(32'(alt_buf_en), 32'h00000001);
			ref_sel_alt <= 1'b0;
			wait_active(1'b0);
			chk(32'(alt_buf_en), k);
			rd_chk(STA, k << 1);
		end
		$display("test alternate buffer done");
		end_of_test();
	end
endmodule
`default_nettype wire
